// [bench/dac_model.sv]
// converter model: turns sign-magnitude samples into a signed level
// assumes dds_pkg compiled first; purely combinational, no clock
`timescale 1ns/1ps
`default_nettype none

module dac_model
  import dds_pkg::*;
(
  // converter input
  input wire sample_t sample,
  // converted level
  output var logic signed [9:0] level
);
  // ****************************************************************
  // conversion
  // ****************************************************************
  logic signed [9:0] mag;
  assign mag = $signed({2'b00, sample[7:0]});
  always_comb
  begin
    level = sample[8] ? -mag : mag;
  end
endmodule

`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench of the sine synthesizer against a reference model
// assumes dds_pkg, table_if, quarter_table and the synthesizer compiled
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import dds_pkg::*;
();
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  freq_t freqWord = 18'h00000;
  logic tableWrEn = 1'b0;
  qaddr_t tableWrAddr = 4'h0;
  mag_t tableWrData = 8'h00;
  sample_t sampleOut;
  phase_t phase;
  logic signed [9:0] level;
  int error_cnt = 0;
  int compares = 0;
  bit run = 0;
  int sineTab[16] = '{8'h0D, 8'h25, 8'h3E, 8'h56, 8'h6D, 8'h83, 8'h98,
    8'hAB, 8'hBD, 8'hCD, 8'hDB, 8'hE7, 8'hF0, 8'hF7, 8'hFC, 8'hFF};
  int mTab[16];
  int mPhase, mRead, mSign, mSamp, mAddr, mLevel;

  sine_wave_synthesizer u_dut (.mclk(mclk), .rst_n(rst_n),
    .freqWord(freqWord), .tableWrEn(tableWrEn),
    .tableWrAddr(tableWrAddr), .tableWrData(tableWrData),
    .sampleOut(sampleOut), .phase(phase));
  dac_model u_dac (.sample(sampleOut), .level(level));

  initial
  begin
    forever #20 mclk = ~mclk;
  end

  // ****************************************************************
  // reference model, updated on each rising edge
  // ****************************************************************
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      mPhase = 0;
      mRead = 0;
      mSign = 0;
      mSamp = 0;
      foreach (mTab[i]) mTab[i] = sineTab[i];
    end
    else
    begin
      mSamp = mSign * 256 + mRead;
      mAddr = ((mPhase >> 16) & 15) ^ (((mPhase >> 20) & 1) ? 15 : 0);
      mRead = mTab[mAddr];
      mSign = (mPhase >> 21) & 1;
      mPhase = (mPhase + int'(freqWord)) % 4194304;
      if (tableWrEn)
        mTab[tableWrAddr] = int'(tableWrData);
    end
    mLevel = (mSamp >= 256) ? 256 - mSamp : mSamp;
  end

  // ****************************************************************
  // comparison at every result
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  always @(negedge mclk)
  begin
    if (run)
    begin
      check("phase", phase, mPhase);
      check("sample", sampleOut, mSamp);
      check("level", level, mLevel);
    end
  end

  task automatic end_test(input string name);
    $display("test %s done, %0d compares so far", name, compares);
  endtask

  task automatic wrap_up;
    $display("compares %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #(40 * 3000);
    error_cnt++;
    wrap_up();
  end

  // ****************************************************************
  // stimulus, driven at the falling edge
  // ****************************************************************
  initial
  begin
    void'($urandom(22));
    repeat (2) @(negedge mclk);
    run = 1;
    check("reset phase", phase, 0);
    rst_n = 1'b1;
    freqWord = 18'h00001;
    repeat (20) @(negedge mclk);
    end_test("unit step");
    freqWord = 18'h3D090;
    repeat (100) @(negedge mclk);
    end_test("top frequency");
    freqWord = 18'h3FFFF;
    repeat (40) @(negedge mclk);
    end_test("wrap");
    freqWord = 18'h00000;
    repeat (20) @(negedge mclk);
    end_test("hold");
    repeat (300)
    begin
      @(negedge mclk);
      freqWord = freq_t'($urandom);
    end
    end_test("frequency changes");
    repeat (200)
    begin
      @(negedge mclk);
      freqWord = freq_t'($urandom);
      tableWrEn = 1'($urandom);
      tableWrAddr = qaddr_t'($urandom);
      tableWrData = mag_t'($urandom);
    end
    @(negedge mclk);
    tableWrEn = 1'b0;
    repeat (40) @(negedge mclk);
    end_test("table rewrite");
    rst_n = 1'b0;
    @(negedge mclk);
    check("second reset phase", phase, 0);
    rst_n = 1'b1;
    freqWord = 18'h20000;
    repeat (60) @(negedge mclk);
    end_test("mid-run reset");
    wrap_up();
  end
endmodule

`default_nettype wire

// [verilog/dds_consts.svh]
// constants of the sine synthesizer: widths, field positions, reset values
// assumes inclusion by bare name from the package and design files
`ifndef DDS_CONSTS_SVH
`define DDS_CONSTS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define FREQ_W 18
`define CNT_W 4
`define ACC_W 22
`define ADDR_W 4
`define MAG_W 8
`define SAMPLE_W 9
`define TABLE_DEPTH 16

// ****************************************************************
// phase fields
// ****************************************************************
`define SIGN_BIT 21
`define MIRROR_BIT 20
`define ADDR_HI 19
`define ADDR_LO 16

// ****************************************************************
// step limits
// ****************************************************************
`define TOP_STEP 18'h3D090
`define STEP_MAX 22'h03FFFF
`define POS_STEP_MAX 6'h04

// ****************************************************************
// reset values and clocking
// ****************************************************************
`define ACC_RESET 22'h000000
`define SAMPLE_RESET 9'h000
`define MAG_RESET 8'h00
`define MCLK_HZ 25000000
`define NOMINAL_HZ 4194304

`endif

// [verilog/dds_pkg.sv]
// types and the default quarter-wave contents of the sine synthesizer
// assumes dds_consts.svh on the include path
`include "dds_consts.svh"

package dds_pkg;

  typedef logic [`ACC_W-1:0] phase_t;
  typedef logic [`FREQ_W-1:0] freq_t;
  typedef logic [`ADDR_W-1:0] qaddr_t;
  typedef logic [`MAG_W-1:0] mag_t;
  typedef logic [`SAMPLE_W-1:0] sample_t;

  // sine of (i + 0.5) sixty-fourths of a turn, scaled to 255
  function automatic mag_t sineDefault(input qaddr_t idx);
    mag_t val;
    val = 8'h00;
    case (idx)
      4'h0: val = 8'h0D;
      4'h1: val = 8'h25;
      4'h2: val = 8'h3E;
      4'h3: val = 8'h56;
      4'h4: val = 8'h6D;
      4'h5: val = 8'h83;
      4'h6: val = 8'h98;
      4'h7: val = 8'hAB;
      4'h8: val = 8'hBD;
      4'h9: val = 8'hCD;
      4'hA: val = 8'hDB;
      4'hB: val = 8'hE7;
      4'hC: val = 8'hF0;
      4'hD: val = 8'hF7;
      4'hE: val = 8'hFC;
      default: val = 8'hFF;
    endcase
    return val;
  endfunction

endpackage

// [verilog/quarter_table.sv]
// rewritable 16 x 8 quarter-wave amplitude store with registered read
// assumes mclk domain only; reset reloads the sine contents
`timescale 1ns/1ps
`default_nettype none
`include "dds_consts.svh"

module quarter_table
  import dds_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // table access
  table_if.store tab
);

  mag_t mem [0:`TABLE_DEPTH-1];

  // ****************************************************************
  // storage
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `TABLE_DEPTH; i++)
      begin
        mem[i] <= sineDefault(qaddr_t'(i));
      end
    end
    else if (tab.wrEn)
    begin
      mem[tab.wrAddr] <= tab.wrData;
    end
  end

  // read returns old contents when the same word is written alongside
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      tab.rdData <= `MAG_RESET;
    else
      tab.rdData <= mem[tab.rdAddr];
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  mag_t curWord;
  assign curWord = mem[tab.rdAddr];

  property p_readData;
    @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |-> tab.rdData == $past(curWord);
  endproperty
  a_readData: assert property (p_readData)
    else $error("table read does not return addressed word");

  property p_writeBack;
    @(posedge mclk) disable iff (!rst_n)
      tab.wrEn ##1 (!tab.wrEn && tab.rdAddr == $past(tab.wrAddr))
        |=> tab.rdData == $past(tab.wrData, 2);
  endproperty
  a_writeBack: assert property (p_writeBack)
    else $error("rewritten table word not read back");

  property p_cvWrite;
    @(posedge mclk) disable iff (!rst_n)
      tab.wrEn ##1 !tab.wrEn ##1 !tab.wrEn;
  endproperty
  c_cvWrite: cover property (p_cvWrite);

endmodule

`default_nettype wire

// [verilog/sine_wave_synthesizer.sv]
// direct digital sine synthesizer: phase accumulator, folded table, samples
// assumes one clock, frequency word and table writes from the mclk domain
`timescale 1ns/1ps
`default_nettype none
`include "dds_consts.svh"

module sine_wave_synthesizer
  import dds_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // frequency control
  input wire freq_t freqWord,
  // table rewrite
  input wire logic tableWrEn,
  input wire qaddr_t tableWrAddr,
  input wire mag_t tableWrData,
  // converter samples
  output var sample_t sampleOut,
  // accumulated phase
  output var phase_t phase
);

  // ****************************************************************
  // phase accumulator
  // ****************************************************************
  // adder width fixed; finer steps would add low bits here
  logic [`FREQ_W:0] next_low;
  logic [`CNT_W-1:0] next_high;

  assign next_low = {1'b0, phase[`FREQ_W-1:0]} + {1'b0, freqWord};
  // top bits count carries only; more of them would need a faster clock
  assign next_high = phase[`ACC_W-1:`FREQ_W]
                   + {{(`CNT_W-1){1'b0}}, next_low[`FREQ_W]};

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      phase <= `ACC_RESET;
    else
      phase <= {next_high, next_low[`FREQ_W-1:0]};
  end

  // ****************************************************************
  // folded table lookup
  // ****************************************************************
  table_if tab ();

  // address width fixed at a 16-word quarter
  assign tab.rdAddr = phase[`ADDR_HI:`ADDR_LO]
                    ^ {`ADDR_W{phase[`MIRROR_BIT]}};
  assign tab.wrEn = tableWrEn;
  assign tab.wrAddr = tableWrAddr;
  assign tab.wrData = tableWrData;

  quarter_table u_table (
    .mclk (mclk),
    .rst_n (rst_n),
    .tab (tab)
  );

  // ****************************************************************
  // sample output
  // ****************************************************************
  logic signDelay;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      signDelay <= 1'b0;
    else
      signDelay <= phase[`SIGN_BIT];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      sampleOut <= `SAMPLE_RESET;
    else
      sampleOut <= {signDelay, tab.rdData};
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  logic tableTouched;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      tableTouched <= 1'b0;
    else if (tableWrEn)
      tableTouched <= 1'b1;
  end

  property p_accStep;
    @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |->
        phase == phase_t'($past(phase) + {4'h0, $past(freqWord)});
  endproperty
  a_accStep: assert property (p_accStep)
    else $error("phase did not advance by the frequency word");

  property p_noPhaseJump;
    @(posedge mclk) disable iff (!rst_n)
      (freqWord != $past(freqWord)) |=>
        phase_t'(phase - $past(phase)) == {4'h0, $past(freqWord)};
  endproperty
  a_noPhaseJump: assert property (p_noPhaseJump)
    else $error("phase jumped on frequency change");

  property p_reset;
    @(posedge mclk)
      !rst_n |=> phase == `ACC_RESET;
  endproperty
  a_reset: assert property (p_reset)
    else $error("phase not cleared by reset");

  property p_upperHold;
    @(posedge mclk) disable iff (!rst_n)
      !next_low[`FREQ_W] |=>
        phase[`ACC_W-1:`FREQ_W] == $past(phase[`ACC_W-1:`FREQ_W]);
  endproperty
  a_upperHold: assert property (p_upperHold)
    else $error("top phase bits moved without a carry");

  property p_upperCarry;
    @(posedge mclk) disable iff (!rst_n)
      next_low[`FREQ_W] |=>
        phase[`ACC_W-1:`FREQ_W] == $past(phase[`ACC_W-1:`FREQ_W]) + 4'h1;
  endproperty
  a_upperCarry: assert property (p_upperCarry)
    else $error("top phase bits missed a carry");

  property p_sign;
    @(posedge mclk) disable iff (!rst_n)
      ($past(rst_n) && $past(rst_n, 2)) |->
        sampleOut[`SAMPLE_W-1] == $past(phase[`SIGN_BIT], 2);
  endproperty
  a_sign: assert property (p_sign)
    else $error("sample sign does not follow top phase bit");

  property p_mirror;
    @(posedge mclk) disable iff (!rst_n)
      ($past(rst_n) && $past(rst_n, 2) && !tableTouched) |->
        sampleOut[`MAG_W-1:0] == sineDefault(
          $past(phase[`ADDR_HI:`ADDR_LO], 2)
          ^ {`ADDR_W{$past(phase[`MIRROR_BIT], 2)}});
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("folded magnitude does not match quarter table");

  // ****************************************************************
  // phase arithmetic assertions
  // ****************************************************************
  property p_lowStep;
    @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |-> phase[`FREQ_W-1:0]
        == freq_t'($past(phase[`FREQ_W-1:0]) + $past(freqWord));
  endproperty
  a_lowStep: assert property (p_lowStep)
    else $error("low phase bits did not add the frequency word");

  property p_stepBound;
    @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |->
        phase_t'(phase - $past(phase)) <= `STEP_MAX;
  endproperty
  a_stepBound: assert property (p_stepBound)
    else $error("phase step exceeds the frequency word range");

  property p_highStep;
    @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |-> 4'(phase[`ACC_W-1:`FREQ_W]
        - $past(phase[`ACC_W-1:`FREQ_W])) <= 4'h1;
  endproperty
  a_highStep: assert property (p_highStep)
    else $error("top phase bits moved by more than one");

  property p_wrap;
    @(posedge mclk) disable iff (!rst_n)
      ($past(rst_n) && phase < $past(phase)) |->
        ($past(phase[`ACC_W-1:`FREQ_W]) == 4'hF
          && phase[`ACC_W-1:`FREQ_W] == 4'h0);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("phase fell back without a counter wrap");

  property p_zeroHold;
    @(posedge mclk) disable iff (!rst_n)
      (freqWord == 18'h00000) |=>
        $stable(phase);
  endproperty
  a_zeroHold: assert property (p_zeroHold)
    else $error("phase moved with a zero frequency word");

  property p_lookupRate;
    @(posedge mclk) disable iff (!rst_n)
      (freqWord <= `TOP_STEP) |=> 6'(phase[`SIGN_BIT:`ADDR_LO]
        - $past(phase[`SIGN_BIT:`ADDR_LO])) <= `POS_STEP_MAX;
  endproperty
  a_lookupRate: assert property (p_lookupRate)
    else $error("table position skipped too far for a top-rate word");

  // ****************************************************************
  // fold, sample and table write assertions
  // ****************************************************************
  property p_directAddr;
    @(posedge mclk) disable iff (!rst_n)
      !phase[`MIRROR_BIT] |->
        tab.rdAddr == phase[`ADDR_HI:`ADDR_LO];
  endproperty
  a_directAddr: assert property (p_directAddr)
    else $error("rising quarter address is not the phase field");

  property p_mirrorAddr;
    @(posedge mclk) disable iff (!rst_n)
      phase[`MIRROR_BIT] |->
        tab.rdAddr == ~phase[`ADDR_HI:`ADDR_LO];
  endproperty
  a_mirrorAddr: assert property (p_mirrorAddr)
    else $error("falling quarter address is not mirrored");

  property p_signDelay;
    @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |->
        signDelay == $past(phase[`SIGN_BIT]);
  endproperty
  a_signDelay: assert property (p_signDelay)
    else $error("sign delay does not hold the top phase bit");

  property p_sampleData;
    @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |->
        sampleOut[`MAG_W-1:0] == $past(tab.rdData);
  endproperty
  a_sampleData: assert property (p_sampleData)
    else $error("sample magnitude is not the table read word");

  property p_tableWrite;
    @(posedge mclk) disable iff (!rst_n)
      tableWrEn |->
        (tab.wrEn && tab.wrAddr == tableWrAddr && tab.wrData == tableWrData);
  endproperty
  a_tableWrite: assert property (p_tableWrite)
    else $error("table write request not passed to the store");

  // ****************************************************************
  // reset and start assertions, then coverage of frequency change, sign flip, mirror and zero hold
  // ****************************************************************
  property p_sampleReset;
    @(posedge mclk)
      !rst_n |=>
        (sampleOut == `SAMPLE_RESET && signDelay == 1'b0);
  endproperty
  a_sampleReset: assert property (p_sampleReset)
    else $error("sample path not cleared by reset");

  property p_firstStep;
    @(posedge mclk)
      (!rst_n ##1 rst_n) |=>
        phase == phase_t'({4'h0, $past(freqWord)});
  endproperty
  a_firstStep: assert property (p_firstStep)
    else $error("first step after reset did not start from zero phase");

  property p_cvFreqChange;
    @(posedge mclk) disable iff (!rst_n)
      (freqWord != $past(freqWord)) ##1 (freqWord == $past(freqWord));
  endproperty
  c_cvFreqChange: cover property (p_cvFreqChange);

  property p_cvSignFlip;
    @(posedge mclk) disable iff (!rst_n)
      $rose(sampleOut[`SAMPLE_W-1]);
  endproperty
  c_cvSignFlip: cover property (p_cvSignFlip);

  property p_cvMirror;
    @(posedge mclk) disable iff (!rst_n)
      $rose(phase[`MIRROR_BIT]) ##1 !tableTouched;
  endproperty
  c_cvMirror: cover property (p_cvMirror);

  property p_cvZeroHold;
    @(posedge mclk) disable iff (!rst_n)
      (freqWord == 18'h00000) ##1 (freqWord == 18'h00000);
  endproperty
  c_cvZeroHold: cover property (p_cvZeroHold);

endmodule

`default_nettype wire

// [verilog/table_if.sv]
// read and write signals between the synthesizer and its quarter table
// assumes dds_pkg compiled first
`timescale 1ns/1ps
`default_nettype none

interface table_if;
  import dds_pkg::*;
  qaddr_t rdAddr;
  mag_t rdData;
  logic wrEn;
  qaddr_t wrAddr;
  mag_t wrData;
  modport store (input rdAddr, input wrEn, input wrAddr, input wrData,
                 output rdData);
  modport user (output rdAddr, output wrEn, output wrAddr, output wrData,
                input rdData);
endinterface

`default_nettype wire
